// File: pec_pkg.sv
// Constants for the receive path error counter block
`default_nettype none
package pec_pkg;
    // =====================================================================
    // Timing
    localparam int unsigned CLK_RATE_HZ          = 10_000_000;
    localparam int unsigned UPDATE_SECOND_S      = 1;
    localparam int unsigned UPDATE_SECOND_CYCLES = UPDATE_SECOND_S * CLK_RATE_HZ;
    localparam int unsigned T1_FAST_FRAMES       = 333;
    localparam int unsigned E1_FAST_FRAMES       = 500;
    localparam int unsigned FRAME_CNT_WIDTH      = 10;
    localparam int unsigned CNT_WIDTH            = 16;

    // =====================================================================
    // Register indices; byte address is four times the index
    localparam logic [7:0]  REG_CONFIG_IDX    = 8'h41;
    localparam logic [7:0]  REG_PATH_HI_IDX   = 8'h44;
    localparam logic [7:0]  REG_PATH_LO_IDX   = 8'h45;
    localparam logic [7:0]  REG_FRAME_HI_IDX  = 8'h46;
    localparam logic [7:0]  REG_FRAME_LO_IDX  = 8'h47;
    localparam logic [7:0]  REG_FAR_HI_IDX    = 8'h48;
    localparam logic [7:0]  REG_FAR_LO_IDX    = 8'h49;
    localparam int unsigned ADDR_WIDTH        = 12;

    // =====================================================================
    // Counter configuration fields and reset values
    localparam int unsigned CFG_MOS_SEL_BIT   = 1;
    localparam int unsigned CFG_FS_REPORT_BIT = 2;
    localparam int unsigned CFG_ACCUM_BIT     = 4;
    localparam int unsigned CFG_INTERVAL_BIT  = 5;
    localparam int unsigned CFG_MANUAL_BIT    = 6;
    localparam logic [7:0]  CFG_RESET         = 8'h00;
    localparam logic [7:0]  CFG_WRITE_MASK    = 8'h7f;
    localparam logic [15:0] COUNT_RESET       = 16'h0000;
endpackage : pec_pkg
`default_nettype wire

// File: pec_sat_counter.sv
// Saturating event counter with clear
`timescale 1ns/1ps
`default_nettype none
module pec_sat_counter #(
    parameter int unsigned WIDTH = pec_pkg::CNT_WIDTH
) (
    input  wire logic             core_clk_in,
    input  wire logic             srst_in,
    input  wire logic             inc_in,
    input  wire logic             clear_in,
    output logic [WIDTH-1:0]      count_out
);
    wire at_max = &count_out;

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            count_out <= WIDTH'(pec_pkg::COUNT_RESET);
        // Event in the clearing cycle starts the new interval
        end else if (clear_in) begin
            count_out <= WIDTH'(inc_in);
        end else if (inc_in && !at_max) begin
            count_out <= count_out + 1'b1;
        end
    end
endmodule : pec_sat_counter
`default_nettype wire

// File: pec_update_timer.sv
// Automatic update interval timer: one second or a fixed frame count
`timescale 1ns/1ps
`default_nettype none
module pec_update_timer #(
    parameter int unsigned SECOND_CYCLES = pec_pkg::UPDATE_SECOND_CYCLES
) (
    input  wire logic core_clk_in,
    input  wire logic srst_in,
    input  wire logic e1_mode_in,
    input  wire logic fast_sel_in,
    input  wire logic frame_in,
    output logic      tick_out
);
    localparam int unsigned SEC_W = $clog2(SECOND_CYCLES + 1);
    localparam int unsigned FW    = pec_pkg::FRAME_CNT_WIDTH;

    logic [SEC_W-1:0] sec_cnt;
    logic [FW-1:0]    frame_cnt;

    wire [FW-1:0] frame_limit = e1_mode_in ? FW'(pec_pkg::E1_FAST_FRAMES - 1)
                                           : FW'(pec_pkg::T1_FAST_FRAMES - 1);
    wire sec_done   = (sec_cnt == SEC_W'(SECOND_CYCLES - 1));
    wire frame_done = frame_in && (frame_cnt >= frame_limit);

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            sec_cnt <= '0;
        end else begin
            sec_cnt <= sec_done ? '0 : sec_cnt + 1'b1;
        end
    end

    // Frame count follows line frames, not the core clock
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            frame_cnt <= '0;
        end else if (frame_in) begin
            frame_cnt <= frame_done ? '0 : frame_cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= fast_sel_in ? frame_done : sec_done;
        end
    end
endmodule : pec_update_timer
`default_nettype wire

// File: pec_error_counters.sv
// Receive path, frame and far-end block error counters with APB access
//
// Behaviour
// - T1 ESF counts every failed CRC6 codeword in the path counter.
// - T1 D4 path counter counts Ft errors, plus Fs errors when enabled.
// - T1 path counter holds while receive sync is lost.
// - E1 path counter counts CRC4 errors; stops on FAS or CRC4 sync loss.
// - Path count is 16 bits, upper byte then lower byte.
// - T1 multiframe mode counts out-of-sync multiframes, also during sync loss.
// - T1 F-bit mode counts Ft (D4) or FPS (ESF) errors; stops on sync loss.
// - E1 frame counter counts FAS word errors; stops on receive sync loss.
// - E1 frame counter ignores FAS errors while searching any alignment.
// - Frame count is 16 bits, upper byte then lower byte.
// - E1 CRC4 only: far-end counter counts each received zero E-bit.
// - Far-end counter stops on FAS or CRC4 sync loss, not CAS.
// - Far-end count is 16 bits, upper byte then lower byte.
// - All counters saturate at maximum, never wrap.
// - Auto update latches and clears each second or every 333/500 frames.
// - Manual bit rising edge latches and clears next clock; host waits.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pec_error_counters #(
    parameter int unsigned SECOND_CYCLES = pec_pkg::UPDATE_SECOND_CYCLES,
    parameter int unsigned CNT_WIDTH     = pec_pkg::CNT_WIDTH
) (
    input  wire logic                            core_clk_in,
    input  wire logic                            srst_in,
    // APB slave
    input  wire logic [pec_pkg::ADDR_WIDTH-1:0]  paddr_in,
    input  wire logic                            psel_in,
    input  wire logic                            penable_in,
    input  wire logic                            pwrite_in,
    input  wire logic [31:0]                     pwdata_in,
    output logic [31:0]                          prdata_out,
    output logic                                 pready_out,
    output logic                                 pslverr_out,
    // Framer state
    input  wire logic                            e1_mode_in,
    input  wire logic                            esf_mode_in,
    input  wire logic                            crc4_mf_mode_in,
    input  wire logic                            receive_sync_lost_in,
    input  wire logic                            fas_sync_lost_in,
    input  wire logic                            crc4_sync_lost_in,
    input  wire logic                            cas_sync_lost_in,
    // Framer event strobes, one cycle each
    input  wire logic                            crc6_err_in,
    input  wire logic                            ft_err_in,
    input  wire logic                            fs_err_in,
    input  wire logic                            fps_err_in,
    input  wire logic                            crc4_err_in,
    input  wire logic                            fas_word_err_in,
    input  wire logic                            multiframe_in,
    input  wire logic                            frame_in,
    input  wire logic                            e_bit_valid_in,
    input  wire logic                            e_bit_in
);
    localparam int unsigned NCNT = 3;
    localparam int unsigned AW   = pec_pkg::ADDR_WIDTH;

    // =====================================================================
    // Address decode
    function automatic logic [AW-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = {2'h0, idx, 2'h0};
    endfunction : byte_addr

    wire sel_cfg      = (paddr_in == byte_addr(pec_pkg::REG_CONFIG_IDX));
    wire sel_path_hi  = (paddr_in == byte_addr(pec_pkg::REG_PATH_HI_IDX));
    wire sel_path_lo  = (paddr_in == byte_addr(pec_pkg::REG_PATH_LO_IDX));
    wire sel_frame_hi = (paddr_in == byte_addr(pec_pkg::REG_FRAME_HI_IDX));
    wire sel_frame_lo = (paddr_in == byte_addr(pec_pkg::REG_FRAME_LO_IDX));
    wire sel_far_hi   = (paddr_in == byte_addr(pec_pkg::REG_FAR_HI_IDX));
    wire sel_far_lo   = (paddr_in == byte_addr(pec_pkg::REG_FAR_LO_IDX));
    wire mapped       = sel_cfg | sel_path_hi | sel_path_lo | sel_frame_hi
                      | sel_frame_lo | sel_far_hi | sel_far_lo;

    wire apb_setup  = psel_in && !penable_in;
    wire apb_access = psel_in && penable_in;
    wire cfg_write  = apb_access && pwrite_in && sel_cfg;

    // =====================================================================
    // Counter configuration
    logic [7:0] counter_config;
    logic       manual_prev;

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            counter_config <= pec_pkg::CFG_RESET;
        end else if (cfg_write) begin
            counter_config <= pwdata_in[7:0] & pec_pkg::CFG_WRITE_MASK;
        end
    end

    wire multiframe_sync_count_select = counter_config[pec_pkg::CFG_MOS_SEL_BIT];
    wire fs_bit_report_enable         = counter_config[pec_pkg::CFG_FS_REPORT_BIT];
    wire accumulation_mode_select     = counter_config[pec_pkg::CFG_ACCUM_BIT];
    wire auto_update_interval_select  = counter_config[pec_pkg::CFG_INTERVAL_BIT];
    wire manual_count_update          = counter_config[pec_pkg::CFG_MANUAL_BIT];

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            manual_prev <= 1'b0;
        end else begin
            manual_prev <= manual_count_update;
        end
    end

    // =====================================================================
    // Update source
    logic auto_tick;

    pec_update_timer #(
        .SECOND_CYCLES (SECOND_CYCLES)
    ) u_timer (
        .core_clk_in (core_clk_in),
        .srst_in     (srst_in),
        .e1_mode_in  (e1_mode_in),
        .fast_sel_in (auto_update_interval_select),
        .frame_in    (frame_in),
        .tick_out    (auto_tick)
    );

    wire manual_edge = accumulation_mode_select && manual_count_update && !manual_prev;
    wire update      = accumulation_mode_select ? manual_edge : auto_tick;

    // =====================================================================
    // Event qualification
    // CRC6 in ESF
    wire t1_path_evt = esf_mode_in ? crc6_err_in
                                   : (ft_err_in || (fs_bit_report_enable && fs_err_in));
    wire path_inc_t1 = !receive_sync_lost_in && t1_path_evt; // gated by sync loss
    // CRC4 gated by FAS and CRC4 sync
    wire path_inc_e1 = crc4_err_in && !fas_sync_lost_in && !crc4_sync_lost_in;
    wire path_inc    = e1_mode_in ? path_inc_e1 : path_inc_t1;

    // out-of-sync multiframes, counted through sync loss
    wire mos_inc     = multiframe_in && receive_sync_lost_in;
    // Ft or FPS errors, gated by sync loss
    wire fbit_inc    = !receive_sync_lost_in && (esf_mode_in ? fps_err_in : ft_err_in);
    // FAS word errors outside any search
    wire frame_inc_e1 = fas_word_err_in && !receive_sync_lost_in && !fas_sync_lost_in
                      && !cas_sync_lost_in && !crc4_sync_lost_in;
    wire frame_inc   = e1_mode_in ? frame_inc_e1
                     : (multiframe_sync_count_select ? mos_inc : fbit_inc);

    wire far_end_inc = e1_mode_in && crc4_mf_mode_in && e_bit_valid_in && !e_bit_in
                     && !fas_sync_lost_in && !crc4_sync_lost_in;

    // =====================================================================
    // Counters and latched counts
    wire  [NCNT-1:0]      inc_vec = {far_end_inc, frame_inc, path_inc};
    logic [CNT_WIDTH-1:0] run_cnt [NCNT];
    logic [CNT_WIDTH-1:0] latched [NCNT];

    genvar gi;
    generate
        for (gi = 0; gi < NCNT; gi++) begin : g_cnt
            pec_sat_counter #(
                .WIDTH (CNT_WIDTH)
            ) u_cnt (
                .core_clk_in (core_clk_in),
                .srst_in     (srst_in),
                .inc_in      (inc_vec[gi]),
                .clear_in    (update),
                .count_out   (run_cnt[gi])
            );

            always_ff @(posedge core_clk_in) begin
                if (srst_in) begin
                    latched[gi] <= CNT_WIDTH'(pec_pkg::COUNT_RESET);
                end else if (update) begin
                    latched[gi] <= run_cnt[gi];
                end
            end
        end
    endgenerate

    wire [CNT_WIDTH-1:0] path_count  = run_cnt[0];
    wire [CNT_WIDTH-1:0] frame_count = run_cnt[1];
    wire [CNT_WIDTH-1:0] far_end_count = run_cnt[2];

    // =====================================================================
    // Register read path
    // upper byte then lower byte
    wire [7:0] rd_byte = sel_cfg      ? counter_config
                       : sel_path_hi  ? latched[0][15:8]
                       : sel_path_lo  ? latched[0][7:0]
                       : sel_frame_hi ? latched[1][15:8]
                       : sel_frame_lo ? latched[1][7:0]
                       : sel_far_hi   ? latched[2][15:8]
                       : sel_far_lo   ? latched[2][7:0]
                       : 8'h00;

    // Data is captured in setup so access completes with no wait state
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (apb_setup && !pwrite_in) begin
            prdata_out <= {24'h00_0000, rd_byte};
        end
    end

    assign pready_out  = 1'b1;
    assign pslverr_out = apb_access && !mapped;

    // =====================================================================
    // Assertions
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    a_esf_crc6_count: assert property (
        !e1_mode_in && esf_mode_in && crc6_err_in && !receive_sync_lost_in
        && !update && !(&path_count) |=> path_count == $past(path_count) + 16'h0001)
        else $error("CRC6 error not counted");

    a_d4_fs_masked: assert property (
        !e1_mode_in && !esf_mode_in && fs_err_in && !ft_err_in
        && !fs_bit_report_enable && !update |=> $stable(path_count))
        else $error("Fs error counted while disabled");

    a_t1_path_hold: assert property (
        !e1_mode_in && receive_sync_lost_in && !update |=> $stable(path_count))
        else $error("T1 path count moved during sync loss");

    a_e1_crc4_gate: assert property (
        e1_mode_in && (fas_sync_lost_in || crc4_sync_lost_in) && !update
        |=> $stable(path_count))
        else $error("CRC4 counted during sync loss");

    a_path_hi_read: assert property (
        apb_setup && !pwrite_in && sel_path_hi && !update
        |=> prdata_out == {24'h00_0000, latched[0][15:8]})
        else $error("Path upper byte read mismatch");

    a_mos_count: assert property (
        !e1_mode_in && multiframe_sync_count_select && multiframe_in
        && receive_sync_lost_in && !update && !(&frame_count)
        |=> frame_count == $past(frame_count) + 16'h0001)
        else $error("Out-of-sync multiframe not counted");

    a_fbit_hold: assert property (
        !e1_mode_in && !multiframe_sync_count_select && receive_sync_lost_in
        && !update |=> $stable(frame_count))
        else $error("F-bit count moved during sync loss");

    a_e1_fas_search: assert property (
        e1_mode_in && (cas_sync_lost_in || receive_sync_lost_in) && !update
        |=> $stable(frame_count))
        else $error("FAS error counted while searching");

    a_far_t1_off: assert property (
        !e1_mode_in && !update |=> $stable(far_end_count))
        else $error("Far-end count moved in T1");

    a_far_gate: assert property (
        e1_mode_in && crc4_sync_lost_in && !update |=> $stable(far_end_count))
        else $error("Far-end count moved during CRC4 loss");

    a_sat_hold: assert property (
        (&path_count) && !update |=> &path_count)
        else $error("Path counter wrapped");

    a_update_latch: assert property (
        update |=> latched[1] == $past(frame_count) && frame_count <= 16'h0001)
        else $error("Update did not latch and clear");

    a_manual_edge: assert property (
        cfg_write && pwdata_in[pec_pkg::CFG_ACCUM_BIT] && pwdata_in[pec_pkg::CFG_MANUAL_BIT]
        && !manual_count_update |=> ##[0:1] update)
        else $error("Manual update missed");

    a_count_ro: assert property (
        apb_access && (sel_path_lo || sel_far_hi) && !update
        |=> $stable(latched[0]) && $stable(latched[2]))
        else $error("Count register disturbed by access");

    a_fs_counted: assert property (
        !e1_mode_in && !esf_mode_in && fs_err_in && fs_bit_report_enable && !update
        && !(&path_count) |=> path_count == $past(path_count) + 16'h0001)
        else $error("Enabled Fs error not counted");

    a_e1_crc4_count: assert property (
        e1_mode_in && crc4_err_in && !fas_sync_lost_in && !crc4_sync_lost_in && !update
        && !(&path_count) |=> path_count == $past(path_count) + 16'h0001)
        else $error("CRC4 error not counted");

    a_path_lo_read: assert property (
        apb_setup && !pwrite_in && sel_path_lo && !update
        |=> prdata_out == {24'h00_0000, latched[0][7:0]})
        else $error("Path lower byte read mismatch");

    a_fbit_count: assert property (
        !e1_mode_in && !multiframe_sync_count_select && !receive_sync_lost_in
        && ((esf_mode_in && fps_err_in) || (!esf_mode_in && ft_err_in)) && !update
        && !(&frame_count) |=> frame_count == $past(frame_count) + 16'h0001)
        else $error("F-bit error not counted");

    a_e1_fas_count: assert property (
        e1_mode_in && fas_word_err_in && !receive_sync_lost_in && !fas_sync_lost_in
        && !cas_sync_lost_in && !crc4_sync_lost_in && !update && !(&frame_count)
        |=> frame_count == $past(frame_count) + 16'h0001)
        else $error("FAS word error not counted");

    a_frame_hi_read: assert property (
        apb_setup && !pwrite_in && sel_frame_hi && !update
        |=> prdata_out == {24'h00_0000, latched[1][15:8]})
        else $error("Frame upper byte read mismatch");

    a_frame_lo_read: assert property (
        apb_setup && !pwrite_in && sel_frame_lo && !update
        |=> prdata_out == {24'h00_0000, latched[1][7:0]})
        else $error("Frame lower byte read mismatch");

    a_far_zero_count: assert property (
        e1_mode_in && crc4_mf_mode_in && e_bit_valid_in && !e_bit_in && !fas_sync_lost_in
        && !crc4_sync_lost_in && !update && !(&far_end_count)
        |=> far_end_count == $past(far_end_count) + 16'h0001)
        else $error("Zero E-bit not counted");

    a_far_fas_gate: assert property (
        e1_mode_in && fas_sync_lost_in && !update |=> $stable(far_end_count))
        else $error("Far-end count moved during FAS loss");

    a_far_hi_read: assert property (
        apb_setup && !pwrite_in && sel_far_hi && !update
        |=> prdata_out == {24'h00_0000, latched[2][15:8]})
        else $error("Far-end upper byte read mismatch");

    a_far_lo_read: assert property (
        apb_setup && !pwrite_in && sel_far_lo && !update
        |=> prdata_out == {24'h00_0000, latched[2][7:0]})
        else $error("Far-end lower byte read mismatch");

    a_frame_sat: assert property (
        (&frame_count) && !update |=> &frame_count)
        else $error("Frame counter wrapped");

    a_update_clear: assert property (
        update |=> latched[0] == $past(path_count) && latched[2] == $past(far_end_count)
        && path_count <= 16'h0001)
        else $error("Update did not latch path and far-end counts");

    c_auto_update:  cover property (!accumulation_mode_select && update);
    c_manual_update: cover property (manual_edge);
    c_saturated:    cover property (&far_end_count);
    c_mos_counted:  cover property (!e1_mode_in && mos_inc);
    c_far_counted:  cover property (far_end_inc);
endmodule : pec_error_counters
`default_nettype wire

// File: pec_framer_model.sv
// Behavioural receive framer: sync state levels and event strobes
`timescale 1ns/1ps
`default_nettype none
module pec_framer_model (
    input  wire logic       core_clk_in,
    output logic      [6:0] state_out,
    output logic      [8:0] strobe_out,
    output logic            e_bit_out
);
    // ================================================================
    // State and strobes, changed just after a rising edge
    logic ebit_val;
    initial begin
        state_out  = 7'h00;
        strobe_out = 9'h000;
        ebit_val   = 1'b1;
    end
    // E-bit value qualified
    // Idle line shows the inverse, so a stale value never looks valid
    assign e_bit_out = strobe_out[8] ? ebit_val : ~ebit_val;
    task automatic set_state(input logic [6:0] s);
        @(posedge core_clk_in);
        state_out <= s;
    endtask : set_state
    // Strobe k for n back-to-back cycles; k of 9 sends an E-bit of one
    task automatic burst(input int k, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk_in);
            strobe_out <= 9'h001 << ((k == 9) ? 8 : k);
            ebit_val   <= (k == 9);
        end
        if (n > 0) begin
            @(posedge core_clk_in);
            strobe_out <= 9'h000;
        end
    endtask : burst
endmodule : pec_framer_model
`default_nettype wire

// File: t1e1_path_error_counters_tb.sv
// Self-checking bench for the receive error counters over APB
`timescale 1ns/1ps
`default_nettype none
module t1e1_path_error_counters_tb;
    // ================================================================
    // Clock, reset and wiring
    logic        core_clk_in = 1'b0;
    logic        srst_in     = 1'b1;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [11:0] paddr       = 12'h000;
    logic [31:0] pwdata      = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready, pslverr, e_bit, err;
    logic [6:0]  st;
    logic [8:0]  sb;
    logic [15:0] v;
    int          fail_count  = 0;
    int          checks      = 0;
    initial forever #50 core_clk_in = ~core_clk_in;
    // Short second so the automatic interval fits the run
    pec_error_counters #(.SECOND_CYCLES(50)) uut (
        .core_clk_in(core_clk_in), .srst_in(srst_in), .paddr_in(paddr), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .e1_mode_in(st[6]), .esf_mode_in(st[5]),
        .crc4_mf_mode_in(st[4]), .receive_sync_lost_in(st[3]), .fas_sync_lost_in(st[2]),
        .crc4_sync_lost_in(st[1]), .cas_sync_lost_in(st[0]), .crc6_err_in(sb[0]),
        .ft_err_in(sb[1]), .fs_err_in(sb[2]), .fps_err_in(sb[3]), .crc4_err_in(sb[4]),
        .fas_word_err_in(sb[5]), .multiframe_in(sb[6]), .frame_in(sb[7]),
        .e_bit_valid_in(sb[8]), .e_bit_in(e_bit));
    pec_framer_model fm (.core_clk_in(core_clk_in), .state_out(st), .strobe_out(sb),
        .e_bit_out(e_bit));
    // ================================================================
    // Tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge core_clk_in);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge core_clk_in);
        penable <= 1'b1;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fail_count++;
            finish_test();
        end
    endtask : apb
    task automatic wcfg(input logic [7:0] d);
        apb(1'b1, pec_pkg::REG_CONFIG_IDX, d);
    endtask : wcfg
    task automatic read16(input logic [7:0] idx, output logic [15:0] val);
        apb(1'b0, idx, 8'h00);
        val[15:8] = rd[7:0];
        apb(1'b0, idx + 8'h01, 8'h00);
        val[7:0] = rd[7:0];
    endtask : read16
    // Nibble k of c is the pulse count of strobe k
    task automatic run(input logic [6:0] s, input logic [7:0] cfg, input logic [39:0] c,
                       input logic [15:0] ep, input logic [15:0] ef, input logic [15:0] ee);
        fm.set_state(s);
        wcfg(cfg | 8'h10);
        for (int k = 0; k < 10; k++) fm.burst(k, int'(c[4*k +: 4]));
        wcfg(cfg | 8'h50);
        repeat (2) @(posedge core_clk_in);
        read16(pec_pkg::REG_PATH_HI_IDX, v);
        check(v, ep);
        read16(pec_pkg::REG_FRAME_HI_IDX, v);
        check(v, ef);
        read16(pec_pkg::REG_FAR_HI_IDX, v);
        check(v, ee);
    endtask : run
    // ================================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge core_clk_in);
        srst_in <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, pec_pkg::REG_PATH_HI_IDX + 8'(i), 8'h00);
            check(rd[15:0], 16'h0000);
        end
        apb(1'b1, pec_pkg::REG_PATH_LO_IDX, 8'hff);
        apb(1'b0, pec_pkg::REG_PATH_LO_IDX, 8'h00);
        check(rd[15:0], 16'h0000);
        apb(1'b0, 8'h80, 8'h00);
        check({15'h0, err}, 16'h0001);
        // Top bit of the configuration reads back as zero
        wcfg(8'hff);
        apb(1'b0, pec_pkg::REG_CONFIG_IDX, 8'h00);
        check(rd[15:0], {8'h00, pec_pkg::CFG_WRITE_MASK});
        run(7'b0100000, 8'h04, 40'h0000002203, 16'd3, 16'd2, 16'd0);
        run(7'b0000000, 8'h00, 40'h0000000320, 16'd2, 16'd2, 16'd0);
        run(7'b0000000, 8'h04, 40'h0000000310, 16'd4, 16'd1, 16'd0);
        run(7'b0000000, 8'h02, 40'h0002000010, 16'd1, 16'd0, 16'd0);
        run(7'b0001000, 8'h02, 40'h0003000020, 16'd0, 16'd3, 16'd0);
        run(7'b0001000, 8'h00, 40'h0000000020, 16'd0, 16'd0, 16'd0);
        run(7'b1010000, 8'h00, 40'h2400320000, 16'd2, 16'd3, 16'd4);
        run(7'b1010001, 8'h00, 40'h0100320000, 16'd2, 16'd0, 16'd1);
        run(7'b1010100, 8'h00, 40'h0200120000, 16'd0, 16'd0, 16'd0);
        run(7'b1010010, 8'h00, 40'h0200120000, 16'd0, 16'd0, 16'd0);
        run(7'b1011000, 8'h00, 40'h0000200000, 16'd0, 16'd0, 16'd0);
        run(7'b1000000, 8'h00, 40'h0300000000, 16'd0, 16'd0, 16'd0);
        // Fast interval: 333 frames in T1, 500 in E1
        for (int i = 0; i < 2; i++) begin
            fm.set_state(i ? 7'b1010000 : 7'b0100000);
            wcfg(8'h20);
            fm.burst(i ? 4 : 0, i + 1);
            fm.burst(7, i ? 499 : 332);
            read16(pec_pkg::REG_PATH_HI_IDX, v);
            check(v, 16'(i));
            fm.burst(7, 1);
            repeat (3) @(posedge core_clk_in);
            read16(pec_pkg::REG_PATH_HI_IDX, v);
            check(v, 16'(i + 1));
        end
        wcfg(8'h00);
        fm.burst(4, 1);
        for (int n = 0; n < 40 && v !== 16'h0001; n++) read16(pec_pkg::REG_PATH_HI_IDX, v);
        check(v, 16'h0001);
        for (int n = 0; n < 40 && v !== 16'h0000; n++) read16(pec_pkg::REG_PATH_HI_IDX, v);
        check(v, 16'h0000);
        // Saturation takes a full 16-bit run of back-to-back errors
        wcfg(8'h10);
        fm.set_state(7'b0100000);
        fm.burst(0, 65537);
        run(7'b0100000, 8'h00, 40'h0, 16'hffff, 16'd0, 16'd0);
        read16(pec_pkg::REG_PATH_HI_IDX, v);
        check(v, 16'hffff);
        finish_test();
    end
endmodule : t1e1_path_error_counters_tb
`default_nettype wire
